// ---- src/pid_irq_pkg.sv ----
// Package for the PID channel interrupt enable block: offsets, reset values, bus and event carriers.
// Assumes a 32-bit host bus slave port whose select already covers this register window.
package pid_irq_pkg;

  localparam int          DATA_W              = 32;
  localparam int          CHANNELS            = 64;
  localparam int          BANKS               = 4;
  localparam int          OFFSET_W            = 12;

  // Status flag registers, write one to clear.
  localparam logic [11:0] DONE_STATUS_LOW_OFS  = 12'h114;
  localparam logic [11:0] DONE_STATUS_HIGH_OFS = 12'h118;
  localparam logic [11:0] ERROR_STATUS_LOW_OFS = 12'h11c;
  localparam logic [11:0] ERROR_STATUS_HIGH_OFS = 12'h120;

  // Interrupt enable registers.
  localparam logic [11:0] DONE_IRQ_ENABLE_LOW_OFS  = 12'h124;
  localparam logic [11:0] DONE_IRQ_ENABLE_HIGH_OFS = 12'h128;
  localparam logic [11:0] ERROR_IRQ_ENABLE_LOW_OFS = 12'h12c;

  localparam logic [31:0] ENABLE_RESET        = 32'h0000_0000;
  localparam logic [31:0] STATUS_RESET        = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO           = 32'h0000_0000;

  // Transfer type codes of the bus; bit 1 set means an active transfer.
  localparam logic [1:0]  TRANS_NONSEQ        = 2'h2;
  localparam logic [1:0]  TRANS_SEQ           = 2'h3;
  localparam logic [1:0]  RESP_OKAY           = 2'h0;

  localparam logic [2:0]  SIZE_BYTE           = 3'h0;
  localparam logic [2:0]  SIZE_HALF           = 3'h1;

  typedef enum logic [2:0] {
    REG_NONE            = 3'b000,
    REG_DONE_STATUS_LO  = 3'b001,
    REG_DONE_STATUS_HI  = 3'b010,
    REG_ERROR_STATUS_LO = 3'b011,
    REG_ERROR_STATUS_HI = 3'b100,
    REG_DONE_ENABLE_LO  = 3'b101,
    REG_DONE_ENABLE_HI  = 3'b110,
    REG_ERROR_ENABLE_LO = 3'b111
  } reg_sel_t;

  typedef struct packed {
    logic        sel;
    logic [31:0] addr;
    logic        write;
    logic [1:0]  trans;
    logic [2:0]  size;
    logic        ready;
  } bus_req_t;

  typedef struct packed {
    logic [63:0] done;
    logic [63:0] error;
  } chan_events_t;

endpackage

// ---- src/pid_flag_bank.sv ----
// One 32-bit bank of sticky channel flags with write-one-to-clear.
// Assumes set pulses and the clear strobe are synchronous to clk.
module pid_flag_bank (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Hardware events and software clear
  input  wire logic [31:0] setPulse,
  input  wire logic        clearEn,
  input  wire logic [31:0] clearMask,
  // Flag state
  output logic      [31:0] flags_r,
  output logic      [31:0] flagsNxt
);

  genvar b;
  generate
    for (b = 0; b < 32; b++) begin : g_bit
      // An event landing in the clearing cycle must not be lost, so set beats clear.
      always_comb begin
        flagsNxt[b] = setPulse[b] | (flags_r[b] & ~(clearEn & clearMask[b]));
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      flags_r <= pid_irq_pkg::STATUS_RESET;
    end else begin
      flags_r <= flagsNxt;
    end
  end

endmodule

// ---- src/pid_channel_irq_enable_masks.sv ----
// Interrupt enable masks and channel flags for the 64 PID filter channels of the transport interface unit.
// Assumes a pipelined 32-bit host bus slave port, selected by the system decoder, on the same clock.
//
// Overview of operation
// - The register at 0x0124 holds one done interrupt enable per channel 0 to 31, bit n for channel n.
// - The register at 0x0128 holds one done interrupt enable per channel 32 to 63, bit n for channel 32 plus n.
// - The register at 0x012c holds one error interrupt enable per channel 0 to 31, bit n for channel n.
// - Every enable bit is read-write, resets to zero, and a one enables its interrupt.
// - Each channel keeps a done flag and an error flag, set by hardware and cleared by writing one.
module pid_channel_irq_enable_masks (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Host bus slave, address phase
  input  wire pid_irq_pkg::bus_req_t   busReq,
  // Host bus slave, data phase
  input  wire logic [31:0]             HWDATA,
  output logic      [31:0]             HRDATA,
  output logic                         HREADYOUT,
  output logic      [1:0]              HRESP,
  // Channel events from the PID filters, one-cycle pulses
  input  wire pid_irq_pkg::chan_events_t chanEvents,
  // Interrupt request
  output logic                         irqRequest
);

  pid_irq_pkg::reg_sel_t addrSel;
  pid_irq_pkg::reg_sel_t wrSel_r;
  logic                  accept;
  logic                  wrPending_r;
  logic [3:0]            laneMask;
  logic [3:0]            wrLanes_r;
  logic [31:0]           wrBitMask;
  logic [31:0]           hrdata_r;
  logic                  hreadyout_r;
  logic [1:0]            hresp_r;
  logic                  irqRequest_r;

  logic [31:0]           channel_done_irq_enable_r;
  logic [31:0]           channel_done_irq_enable_nxt;
  logic [31:0]           upper_channel_done_irq_enable_r;
  logic [31:0]           upper_channel_done_irq_enable_nxt;
  logic [31:0]           channel_error_irq_enable_r;
  logic [31:0]           channel_error_irq_enable_nxt;

  logic [31:0]           bankSet   [pid_irq_pkg::BANKS];
  logic                  bankClear [pid_irq_pkg::BANKS];
  logic [31:0]           bankFlags [pid_irq_pkg::BANKS];
  logic [31:0]           bankNxt   [pid_irq_pkg::BANKS];

  // Address decode of the low offset bits; anything else is unmapped.
  function automatic pid_irq_pkg::reg_sel_t decode(input logic [11:0] ofs);
    pid_irq_pkg::reg_sel_t s;
    s = pid_irq_pkg::REG_NONE;
    unique case (ofs)
      pid_irq_pkg::DONE_STATUS_LOW_OFS:      s = pid_irq_pkg::REG_DONE_STATUS_LO;
      pid_irq_pkg::DONE_STATUS_HIGH_OFS:     s = pid_irq_pkg::REG_DONE_STATUS_HI;
      pid_irq_pkg::ERROR_STATUS_LOW_OFS:     s = pid_irq_pkg::REG_ERROR_STATUS_LO;
      pid_irq_pkg::ERROR_STATUS_HIGH_OFS:    s = pid_irq_pkg::REG_ERROR_STATUS_HI;
      pid_irq_pkg::DONE_IRQ_ENABLE_LOW_OFS:  s = pid_irq_pkg::REG_DONE_ENABLE_LO;
      pid_irq_pkg::DONE_IRQ_ENABLE_HIGH_OFS: s = pid_irq_pkg::REG_DONE_ENABLE_HI;
      pid_irq_pkg::ERROR_IRQ_ENABLE_LOW_OFS: s = pid_irq_pkg::REG_ERROR_ENABLE_LO;
      default:                               s = pid_irq_pkg::REG_NONE;
    endcase
    return s;
  endfunction

  assign accept  = busReq.sel & busReq.ready & busReq.trans[1];
  assign addrSel = decode({busReq.addr[11:2], 2'b00});

  // Byte lanes touched by a narrow write, so sub-word stores leave other bytes alone.
  always_comb begin
    laneMask = 4'hf;
    if (busReq.size == pid_irq_pkg::SIZE_BYTE) begin
      laneMask = 4'h1 << busReq.addr[1:0];
    end else if (busReq.size == pid_irq_pkg::SIZE_HALF) begin
      laneMask = busReq.addr[1] ? 4'hc : 4'h3;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign wrBitMask[g*8 +: 8] = {8{wrLanes_r[g]}};
    end
  endgenerate

  // Address phase capture; the write itself lands at the end of the data phase.
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPending_r <= 1'b0;
      wrSel_r     <= pid_irq_pkg::REG_NONE;
      wrLanes_r   <= 4'h0;
    end else begin
      wrPending_r <= accept & busReq.write;
      wrSel_r     <= accept ? addrSel : pid_irq_pkg::REG_NONE;
      wrLanes_r   <= laneMask;
    end
  end

  // Enable registers: plain read-write, merged by byte lane.
  always_comb begin
    channel_done_irq_enable_nxt       = channel_done_irq_enable_r;
    upper_channel_done_irq_enable_nxt = upper_channel_done_irq_enable_r;
    channel_error_irq_enable_nxt      = channel_error_irq_enable_r;
    if (wrPending_r) begin
      unique case (wrSel_r)
        pid_irq_pkg::REG_DONE_ENABLE_LO:
          channel_done_irq_enable_nxt = (channel_done_irq_enable_r & ~wrBitMask)
                                        | (HWDATA & wrBitMask);
        pid_irq_pkg::REG_DONE_ENABLE_HI:
          upper_channel_done_irq_enable_nxt = (upper_channel_done_irq_enable_r & ~wrBitMask)
                                              | (HWDATA & wrBitMask);
        pid_irq_pkg::REG_ERROR_ENABLE_LO:
          channel_error_irq_enable_nxt = (channel_error_irq_enable_r & ~wrBitMask)
                                         | (HWDATA & wrBitMask);
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      channel_done_irq_enable_r <= pid_irq_pkg::ENABLE_RESET;
    end else begin
      channel_done_irq_enable_r <= channel_done_irq_enable_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      upper_channel_done_irq_enable_r <= pid_irq_pkg::ENABLE_RESET;
    end else begin
      upper_channel_done_irq_enable_r <= upper_channel_done_irq_enable_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      channel_error_irq_enable_r <= pid_irq_pkg::ENABLE_RESET;
    end else begin
      channel_error_irq_enable_r <= channel_error_irq_enable_nxt;
    end
  end

  // Flag banks: done low, done high, error low, error high.
  assign bankSet[0] = chanEvents.done[31:0];
  assign bankSet[1] = chanEvents.done[63:32];
  assign bankSet[2] = chanEvents.error[31:0];
  assign bankSet[3] = chanEvents.error[63:32];
  assign bankClear[0] = wrPending_r & (wrSel_r == pid_irq_pkg::REG_DONE_STATUS_LO);
  assign bankClear[1] = wrPending_r & (wrSel_r == pid_irq_pkg::REG_DONE_STATUS_HI);
  assign bankClear[2] = wrPending_r & (wrSel_r == pid_irq_pkg::REG_ERROR_STATUS_LO);
  assign bankClear[3] = wrPending_r & (wrSel_r == pid_irq_pkg::REG_ERROR_STATUS_HI);

  generate
    for (g = 0; g < pid_irq_pkg::BANKS; g++) begin : g_bank
      pid_flag_bank u_bank (
        .clk       (clk),
        .rst       (rst),
        .setPulse  (bankSet[g]),
        .clearEn   (bankClear[g]),
        .clearMask (HWDATA & wrBitMask),
        .flags_r   (bankFlags[g]),
        .flagsNxt  (bankNxt[g])
      );
    end
  endgenerate

  // Read data is taken from the next-state values, so a read straight after a write sees the write.
  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata_r <= pid_irq_pkg::READ_ZERO;
    end else if (accept & ~busReq.write) begin
      unique case (addrSel)
        pid_irq_pkg::REG_DONE_STATUS_LO:  hrdata_r <= bankNxt[0];
        pid_irq_pkg::REG_DONE_STATUS_HI:  hrdata_r <= bankNxt[1];
        pid_irq_pkg::REG_ERROR_STATUS_LO: hrdata_r <= bankNxt[2];
        pid_irq_pkg::REG_ERROR_STATUS_HI: hrdata_r <= bankNxt[3];
        pid_irq_pkg::REG_DONE_ENABLE_LO:  hrdata_r <= channel_done_irq_enable_nxt;
        pid_irq_pkg::REG_DONE_ENABLE_HI:  hrdata_r <= upper_channel_done_irq_enable_nxt;
        pid_irq_pkg::REG_ERROR_ENABLE_LO: hrdata_r <= channel_error_irq_enable_nxt;
        default:                          hrdata_r <= pid_irq_pkg::READ_ZERO;
      endcase
    end
  end

  // Zero-wait-state slave; unmapped offsets answer okay, reads as zero, writes dropped.
  always_ff @(posedge clk) begin
    if (rst) begin
      hreadyout_r <= 1'b1;
    end else begin
      hreadyout_r <= 1'b1;
    end
  end

  // The slave never signals an error, but the response still leaves a flop so no output path is combinational.
  always_ff @(posedge clk) begin
    if (rst) begin
      hresp_r <= pid_irq_pkg::RESP_OKAY;
    end else begin
      hresp_r <= pid_irq_pkg::RESP_OKAY;
    end
  end

  // Error enables exist only for channels 0 to 31, so high-bank error flags never raise the request.
  always_ff @(posedge clk) begin
    if (rst) begin
      irqRequest_r <= 1'b0;
    end else begin
      irqRequest_r <= |(bankFlags[0] & channel_done_irq_enable_r)
                      | |(bankFlags[1] & upper_channel_done_irq_enable_r)
                      | |(bankFlags[2] & channel_error_irq_enable_r);
    end
  end

  assign HRDATA     = hrdata_r;
  assign HREADYOUT  = hreadyout_r;
  assign HRESP      = hresp_r;
  assign irqRequest = irqRequest_r;

endmodule

// ---- test/pid_channel_irq_enable_masks_chk.sv ----
// Checker for the PID channel interrupt enable block, watching its ports only.
// Assumes narrow writes follow the byte-lane rule of the host bus; the mirror merges them lane by lane.
module pid_channel_irq_enable_masks_chk (
  // Clock and reset
  input wire logic                      clk,
  input wire logic                      rst,
  // Host bus
  input wire pid_irq_pkg::bus_req_t     busReq,
  input wire logic [31:0]               HWDATA,
  input wire logic [31:0]               HRDATA,
  input wire logic                      HREADYOUT,
  input wire logic [1:0]                HRESP,
  // Events and request
  input wire pid_irq_pkg::chan_events_t chanEvents,
  input wire logic                      irqRequest
);
  logic        acc;
  logic        hit;
  logic        act;
  logic        pendWr_r;
  logic        rdTaken_r;
  logic        seenEvt_r;
  logic [1:0]  idx_r;
  logic [31:0] shadow_r [4];
  logic [3:0]  lanes;
  logic [3:0]  lanes_r;
  logic [31:0] laneBits;
  always_comb begin
    lanes = 4'hf;
    if (busReq.size == 3'h0) begin
      lanes = 4'h1 << busReq.addr[1:0];
    end else if (busReq.size == 3'h1) begin
      lanes = busReq.addr[1] ? 4'hc : 4'h3;
    end
  end
  assign laneBits = {{8{lanes_r[3]}}, {8{lanes_r[2]}}, {8{lanes_r[1]}}, {8{lanes_r[0]}}};
  assign acc = busReq.sel & busReq.ready & busReq.trans[1];
  assign hit = busReq.addr[11:4] == 8'h12 && busReq.addr[3:2] != 2'h0;
  assign act = (|chanEvents) | (acc & busReq.write);
  always_ff @(posedge clk) begin
    pendWr_r <= !rst && acc && busReq.write && hit;
    lanes_r <= lanes;
    rdTaken_r <= !rst && acc && !busReq.write;
    idx_r <= busReq.addr[3:2];
  end
  // The mirror updates on the same edge as the design, so a read right behind a write sees the new word.
  always_ff @(posedge clk) begin
    if (rst) begin
      shadow_r <= '{default: 32'h0};
    end else if (pendWr_r) begin
      shadow_r[idx_r] <= (shadow_r[idx_r] & ~laneBits) | (HWDATA & laneBits);
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      seenEvt_r <= 1'b0;
    end else if (|chanEvents) begin
      seenEvt_r <= 1'b1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_rst_values; $fell(rst) |-> HRDATA == 32'h0 && !irqRequest; endproperty
  a_rst_values: assert property (p_rst_values) else $error("outputs not cleared by reset");
  property p_bus_okay; HREADYOUT && HRESP == 2'h0; endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus answer not zero-wait okay");
  property p_enable_read; acc && !busReq.write && hit |=> HRDATA == shadow_r[idx_r]; endproperty
  a_enable_read: assert property (p_enable_read) else $error("enable read mismatch");
  property p_read_holds; !rdTaken_r |-> $stable(HRDATA); endproperty
  a_read_holds: assert property (p_read_holds) else $error("read data moved without a read");
  property p_irq_cause; $changed(irqRequest) |-> $past(act, 1) || $past(act, 2) || $past(act, 3); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("request changed without a cause");
  property p_irq_quiet; !seenEvt_r |-> !irqRequest; endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("request raised before any event");
endmodule

// ---- test/pid_channel_irq_enable_masks_tb_top.sv ----
// Bench for the PID channel interrupt enable block: register access and per-channel event cases.
// Assumes transfers are spaced two cycles apart; bus ready is dropped once to show an ignored transfer.
module pid_channel_irq_enable_masks_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                      clk = 1'b0;
  logic                      rst = 1'b1;
  pid_irq_pkg::bus_req_t     busReq = '{ready: 1'b1, default: '0};
  logic [31:0]               HWDATA = 32'h0;
  logic [31:0]               HRDATA;
  logic                      HREADYOUT;
  logic [1:0]                HRESP;
  pid_irq_pkg::chan_events_t chanEvents = '0;
  logic                      irqRequest;
  int                        mismatches = 0;
  int                        total_checks = 0;
  logic [2:0]                xferSize = 3'h2;
  int                        chs [6] = '{5, 63, 21, 40, 0, 31};
  bit                        errs [6] = '{0, 0, 1, 1, 0, 1};
  bit                        ens [6] = '{1, 1, 1, 1, 0, 1};
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin mismatches++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
  always #5 clk = ~clk;
  pid_channel_irq_enable_masks u_pid_channel_irq_enable_masks (.clk(clk), .rst(rst), .busReq(busReq),
    .HWDATA(HWDATA), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .chanEvents(chanEvents),
    .irqRequest(irqRequest));
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic xfer(logic [11:0] ofs, logic wr, logic [31:0] d);
    busReq.sel = 1'b1;
    busReq.trans = pid_irq_pkg::TRANS_NONSEQ;
    busReq.write = wr;
    busReq.addr = {20'h0, ofs};
    busReq.size = xferSize;
    step(1);
    busReq.sel = 1'b0;
    busReq.trans = 2'h0;
    HWDATA = d;
    step(1);
  endtask
  task automatic rd(string nm, logic [11:0] ofs, logic [31:0] ex);
    xfer(ofs, 1'b0, 32'h0);
    `CHK(nm, ex, HRDATA)
  endtask
  task automatic evt(int ch, bit err, bit en);
    logic [11:0] eo;
    logic [11:0] so;
    logic [31:0] m;
    logic        ex;
    m = 32'h1 << (ch % 32);
    eo = err ? 12'h12c : (ch < 32 ? 12'h124 : 12'h128);
    so = err ? (ch < 32 ? 12'h11c : 12'h120) : (ch < 32 ? 12'h114 : 12'h118);
    // Error enables exist only for channels 0 to 31, so upper-channel error flags never reach the request.
    ex = en && !(err && ch >= 32);
    xfer(eo, 1'b1, en ? m : 32'h0);
    if (err) chanEvents.error[ch] = 1'b1;
    else chanEvents.done[ch] = 1'b1;
    step(1);
    chanEvents = '0;
    step(2);
    `CHK("irq raised", ex, irqRequest)
    rd("flag set", so, m);
    xfer(so, 1'b1, m);
    step(1);
    `CHK("irq cleared", 1'b0, irqRequest)
    rd("flag cleared", so, 32'h0);
    xfer(eo, 1'b1, 32'h0);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    step(6);
    rst = 1'b0;
    for (int i = 0; i < 3; i++) rd("enable reset", 12'h124 + 12'(4 * i), 32'h0);
    `CHK("irq at reset", 1'b0, irqRequest)
    $display("test reset values done");
    for (int i = 0; i < 3; i++) xfer(12'h124 + 12'(4 * i), 1'b1, 32'ha5c3_0f00 + 32'(i));
    for (int i = 0; i < 3; i++) rd("enable rw", 12'h124 + 12'(4 * i), 32'ha5c3_0f00 + 32'(i));
    xfer(12'h130, 1'b1, 32'hffff_ffff);
    rd("unmapped", 12'h130, 32'h0);
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    for (int i = 0; i < 3; i++) rd("enable after reset", 12'h124 + 12'(4 * i), 32'h0);
    busReq.ready = 1'b0;
    xfer(12'h124, 1'b1, 32'hffff_ffff);
    busReq.ready = 1'b1;
    xferSize = 3'h0;
    xfer(12'h125, 1'b1, 32'hffff_ffff);
    xferSize = 3'h1;
    xfer(12'h12a, 1'b1, 32'hffff_ffff);
    xferSize = 3'h2;
    rd("byte lane", 12'h124, 32'h0000_ff00);
    rd("half lane", 12'h128, 32'hffff_0000);
    for (int i = 0; i < 3; i++) xfer(12'h124 + 12'(4 * i), 1'b1, 32'h0);
    $display("test register access done");
    for (int i = 0; i < 6; i++) evt(chs[i], errs[i], ens[i]);
    $display("test channel events done");
    wrap_up();
  end
  initial begin
    #50000;
    mismatches++;
    wrap_up();
  end
endmodule
bind pid_channel_irq_enable_masks pid_channel_irq_enable_masks_chk u_pid_channel_irq_enable_masks_chk (
  .clk(clk), .rst(rst), .busReq(busReq), .HWDATA(HWDATA), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .chanEvents(chanEvents), .irqRequest(irqRequest));
